// ---- design/dmes_sequencer.sv ----
`include "dmes_map.svh"
`default_nettype none
// Drive mode select and enable sequencer behind the object write port
module dmes_sequencer
    import dmes_pkg::*;
#(
    parameter int VEL_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    output logic [31:0] obj_rdata,
    output logic obj_ack,
    output logic obj_err,
    input wire logic [15:0] accel_cfg,
    input wire logic [15:0] decel_cfg,
    input wire logic [15:0] torque_ramp_cfg,
    input wire logic [15:0] speed_limit_cfg,
    input wire logic [15:0] gear_num,
    input wire logic [15:0] gear_den,
    output logic servo_enabled,
    output logic [7:0] display_code,
    output dmes_op_t active_op,
    output logic motion_active,
    output logic move_start,
    output logic [31:0] pos_cmd,
    output logic signed [VEL_W-1:0] vel_cmd,
    output logic signed [15:0] trq_cmd_permille
);

    // ****************************************
    // Object storage
    // ****************************************
    logic [15:0] cmd_word_ff;          // Last command word
    logic [7:0] mode_sel_ff;           // Mode object value
    logic [15:0] torque_sp_ff;         // Units of 0.1 % rated torque
    logic [31:0] position_sp_ff;       // Target position
    logic [31:0] velocity_sp_ff;       // Target velocity before gearing
    dmes_state_t state_ff;
    dmes_state_t nxt_state;
    dmes_op_t nxt_op;
    logic signed [VEL_W-1:0] geared_vel;
    logic [31:0] rdata_mux;
    logic hit;
    logic cmd_wr;

    // Decoded address hit for any known object
    always_comb begin
        case (obj_index)
            `DMES_OFS_CMD, `DMES_OFS_MODE, `DMES_OFS_TRQ,
            `DMES_OFS_POS, `DMES_OFS_VEL: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    assign cmd_wr = obj_wr && (obj_index == `DMES_OFS_CMD);

    // ****************************************
    // Object writes
    // ****************************************
    // Command word store
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_word_ff <= 16'h0000;
        end else if (cmd_wr) begin
            cmd_word_ff <= obj_wdata[15:0];
        end
    end

    // Mode object; the host sets it before enabling, so it is held as written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_sel_ff <= 8'h00;
        end else if (obj_wr && obj_index == `DMES_OFS_MODE) begin
            mode_sel_ff <= obj_wdata[7:0];
        end
    end

    // Torque setpoint, taken as signed tenths of a percent
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            torque_sp_ff <= 16'h0000;
        end else if (obj_wr && obj_index == `DMES_OFS_TRQ) begin
            torque_sp_ff <= obj_wdata[15:0];
        end
    end

    // Position setpoint, latched ahead of the start word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            position_sp_ff <= `DMES_RST_WORD;
        end else if (obj_wr && obj_index == `DMES_OFS_POS) begin
            position_sp_ff <= obj_wdata;
        end
    end

    // Velocity setpoint; the host only writes it once enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            velocity_sp_ff <= `DMES_RST_WORD;
        end else if (obj_wr && obj_index == `DMES_OFS_VEL) begin
            velocity_sp_ff <= obj_wdata;
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    always_comb begin
        case (mode_sel_ff)
            `DMES_MODE_CSV: nxt_op = DMES_OP_CSV;
            `DMES_MODE_CST: nxt_op = DMES_OP_CST;
            `DMES_MODE_PP: nxt_op = DMES_OP_PP;
            `DMES_MODE_PV: nxt_op = DMES_OP_PV;
            `DMES_MODE_PT: nxt_op = DMES_OP_PT;
            `DMES_MODE_HOME: nxt_op = DMES_OP_HOME;
            `DMES_MODE_CSP: nxt_op = DMES_OP_CSP;
            default: nxt_op = DMES_OP_NONE;
        endcase
    end

    // Registered decode keeps the mode outputs glitch free
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_op <= DMES_OP_NONE;
        end else begin
            active_op <= nxt_op;
        end
    end

    // ****************************************
    // Enable sequence
    // ****************************************
    // Only the exact 6, 7, 15 order reaches enabled; any stray word
    // drops back so a half-finished sequence cannot energise the motor
    always_comb begin
        nxt_state = state_ff;
        if (cmd_wr) begin
            case (state_ff)
                DMES_ST_DISABLED: begin
                    if (obj_wdata[15:0] == `DMES_CW_SHUTDOWN) begin
                        nxt_state = DMES_ST_READY;
                    end
                end
                DMES_ST_READY: begin
                    if (obj_wdata[15:0] == `DMES_CW_SWITCH_ON) begin
                        nxt_state = DMES_ST_SWITCHED;
                    end else if (obj_wdata[15:0] != `DMES_CW_SHUTDOWN) begin
                        nxt_state = DMES_ST_DISABLED;
                    end
                end
                DMES_ST_SWITCHED: begin
                    if (obj_wdata[15:0] == `DMES_CW_ENABLE) begin
                        nxt_state = DMES_ST_ENABLED;
                    end else if (obj_wdata[15:0] == `DMES_CW_SHUTDOWN) begin
                        nxt_state = DMES_ST_READY;
                    end else begin
                        nxt_state = DMES_ST_DISABLED;
                    end
                end
                DMES_ST_ENABLED: begin
                    if (obj_wdata[15:0] == `DMES_CW_SHUTDOWN) begin
                        nxt_state = DMES_ST_READY;
                    end
                end
                default: nxt_state = DMES_ST_DISABLED;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= DMES_ST_DISABLED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign servo_enabled = (state_ff == DMES_ST_ENABLED);

    // ****************************************
    // Display echo
    // ****************************************
    // Blank until enabled, then 8 followed by the mode number
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            display_code <= `DMES_DISP_IDLE;
        end else if (nxt_state == DMES_ST_ENABLED) begin
            display_code <= {`DMES_DISP_PREFIX, mode_sel_ff[3:0]};
        end else begin
            display_code <= `DMES_DISP_IDLE;
        end
    end

    // ****************************************
    // Motion commands
    // ****************************************
    // Start pulse for a profile position move on word 31 or 95
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            move_start <= 1'b0;
        end else begin
            move_start <= cmd_wr && servo_enabled && active_op == DMES_OP_PP &&
                (obj_wdata[15:0] == `DMES_CW_START_A ||
                 obj_wdata[15:0] == `DMES_CW_START_B);
        end
    end

    // Target position handed on every cycle while enabled in CSP or PP mode, not only at the start pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_cmd <= `DMES_RST_WORD;
        end else if (!servo_enabled) begin
            pos_cmd <= `DMES_RST_WORD;
        end else if (active_op == DMES_OP_CSP || active_op == DMES_OP_PP) begin
            pos_cmd <= position_sp_ff;
        end
    end

    // Electronic gear applied before the speed command
    dmes_gear_scale #(
        .WIDTH(VEL_W)
    ) u_gear (
        .clk(clk),
        .rst_n(rst_n),
        .vel_in(velocity_sp_ff[VEL_W-1:0]),
        .gear_num(gear_num),
        .gear_den(gear_den),
        .vel_out(geared_vel)
    );

    // Speed command; zero ramp limits hold profile velocity still
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vel_cmd <= '0;
        end else if (!servo_enabled) begin
            vel_cmd <= '0;
        end else if (active_op == DMES_OP_CSV) begin
            vel_cmd <= geared_vel;
        end else if (active_op == DMES_OP_PV) begin
            if (accel_cfg == 16'h0000 || decel_cfg == 16'h0000) begin
                vel_cmd <= '0;
            end else begin
                vel_cmd <= geared_vel;
            end
        end else begin
            vel_cmd <= '0;
        end
    end

    // Torque command in tenths of a percent of rated torque
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trq_cmd_permille <= 16'sh0000;
        end else if (!servo_enabled) begin
            trq_cmd_permille <= 16'sh0000;
        end else if (active_op == DMES_OP_CST) begin
            trq_cmd_permille <= $signed(torque_sp_ff);
        end else if (active_op == DMES_OP_PT) begin
            if (torque_ramp_cfg == 16'h0000 || speed_limit_cfg == 16'h0000) begin
                trq_cmd_permille <= 16'sh0000;
            end else begin
                trq_cmd_permille <= $signed(torque_sp_ff);
            end
        end else begin
            trq_cmd_permille <= 16'sh0000;
        end
    end

    // Motion flag tracks any nonzero speed or torque command, or homing, CSP or PP mode, while enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            motion_active <= 1'b0;
        end else begin
            motion_active <= servo_enabled && nxt_state == DMES_ST_ENABLED &&
                (vel_cmd != '0 || trq_cmd_permille != 16'sh0000 ||
                 active_op == DMES_OP_HOME || active_op == DMES_OP_CSP ||
                 active_op == DMES_OP_PP);
        end
    end

    // ****************************************
    // Object reads
    // ****************************************
    always_comb begin
        case (obj_index)
            `DMES_OFS_CMD: rdata_mux = {16'h0000, cmd_word_ff};
            `DMES_OFS_MODE: rdata_mux = {24'h000000, mode_sel_ff};
            `DMES_OFS_TRQ: rdata_mux = {16'h0000, torque_sp_ff};
            `DMES_OFS_POS: rdata_mux = position_sp_ff;
            `DMES_OFS_VEL: rdata_mux = velocity_sp_ff;
            default: rdata_mux = 32'h0000_0000;
        endcase
    end

    // One-cycle answer to every access; unknown index flags an error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            obj_rdata <= 32'h0000_0000;
            obj_ack <= 1'b0;
            obj_err <= 1'b0;
        end else begin
            obj_rdata <= obj_rd ? rdata_mux : 32'h0000_0000;
            obj_ack <= obj_wr || obj_rd;
            obj_err <= (obj_wr || obj_rd) && !hit;
        end
    end
endmodule
`default_nettype wire

// ---- design/dmes_map.svh ----
// Behaviour
// - Mode value 9 selects cyclic synchronous velocity
// - Mode value 10 selects cyclic synchronous torque
// - Mode value 1 selects profile position
// - Mode value 3 selects profile velocity
// - Mode value 4 selects profile torque
// - Mode value 6 selects homing, set first
// - Mode value 8 selects cyclic synchronous position
// - Command words 6, 7, 15 enable servo
// - Display shows 8 then active mode hex
// - Position then command 31 or 95 starts move
// - Torque setpoint unit is 0.1 percent rated
// - Command word 6 after run disables, stops motion
// - Profile velocity idle while accel or decel zero
// - Profile torque idle while ramp or limit zero
// - Velocity command scaled by electronic gear ratio
`ifndef DMES_MAP_SVH
`define DMES_MAP_SVH

// ****************************************
// Object indices
// ****************************************
`define DMES_OFS_CMD 16'h6040
`define DMES_OFS_MODE 16'h6060
`define DMES_OFS_TRQ 16'h6071
`define DMES_OFS_POS 16'h607A
`define DMES_OFS_VEL 16'h60FF

// ****************************************
// Command word values
// ****************************************
`define DMES_CW_SHUTDOWN 16'h0006
`define DMES_CW_SWITCH_ON 16'h0007
`define DMES_CW_ENABLE 16'h000F
`define DMES_CW_START_A 16'h001F
`define DMES_CW_START_B 16'h005F

// ****************************************
// Mode values
// ****************************************
`define DMES_MODE_PP 8'h01
`define DMES_MODE_PV 8'h03
`define DMES_MODE_PT 8'h04
`define DMES_MODE_HOME 8'h06
`define DMES_MODE_CSP 8'h08
`define DMES_MODE_CSV 8'h09
`define DMES_MODE_CST 8'h0A

// ****************************************
// Display and reset values
// ****************************************
`define DMES_DISP_PREFIX 4'h8
`define DMES_DISP_IDLE 8'h00
`define DMES_RST_WORD 32'h0000_0000

`endif

// ---- design/dmes_pkg.sv ----
`default_nettype none
package dmes_pkg;
    // Operating mode decoded from the mode object, one-hot
    typedef enum logic [7:0] {
        DMES_OP_NONE = 8'h01,
        DMES_OP_PP = 8'h02,
        DMES_OP_PV = 8'h04,
        DMES_OP_PT = 8'h08,
        DMES_OP_HOME = 8'h10,
        DMES_OP_CSP = 8'h20,
        DMES_OP_CSV = 8'h40,
        DMES_OP_CST = 8'h80
    } dmes_op_t;

    // Enable sequence state, one-hot
    typedef enum logic [3:0] {
        DMES_ST_DISABLED = 4'h1,
        DMES_ST_READY = 4'h2,
        DMES_ST_SWITCHED = 4'h4,
        DMES_ST_ENABLED = 4'h8
    } dmes_state_t;
endpackage
`default_nettype wire

// ---- design/dmes_gear_scale.sv ----
`default_nettype none
// Scales a velocity command by numerator/denominator of the gear ratio
module dmes_gear_scale #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [WIDTH-1:0] vel_in,
    input wire logic [15:0] gear_num,
    input wire logic [15:0] gear_den,
    output logic signed [WIDTH-1:0] vel_out
);
    // Full-width product so no bits are lost before the divide
    logic signed [WIDTH+16:0] product;
    logic signed [WIDTH+16:0] quotient;

    // ****************************************
    // Combinational scaling
    // ****************************************
    always_comb begin
        product = vel_in * $signed({1'b0, gear_num});
        // Zero denominator would be undefined; treat it as no motion
        if (gear_den == 16'h0000) begin
            quotient = '0;
        end else begin
            quotient = product / $signed({1'b0, gear_den});
        end
    end

    // Registered result keeps the divider off the output timing path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vel_out <= '0;
        end else begin
            vel_out <= quotient[WIDTH-1:0];
        end
    end
endmodule
`default_nettype wire

// ---- bench/dmes_seq_asserts.sv ----
`include "dmes_map.svh"
`default_nettype none
// ****
// Object port checker
// ****
module dmes_seq_asserts
    import dmes_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    input wire logic obj_ack,
    input wire logic obj_err,
    input wire logic [15:0] accel_cfg,
    input wire logic servo_enabled,
    input wire logic [7:0] display_code,
    input wire dmes_op_t active_op,
    input wire logic motion_active,
    input wire logic move_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic acc; // Any access taken
    logic cmd; // Control word write
    logic known; // Index names an object
    assign acc = obj_wr || obj_rd;
    assign cmd = obj_wr && obj_index == `DMES_OFS_CMD;
    assign known = obj_index inside {`DMES_OFS_CMD, `DMES_OFS_MODE, `DMES_OFS_TRQ,
        `DMES_OFS_POS, `DMES_OFS_VEL};
    // Answer exactly one edge later, never unasked
    a_ack_follows: assert property (acc |=> obj_ack) else $error("no ack");
    a_ack_cause: assert property (obj_ack |-> $past(acc)) else $error("stray ack");
    a_err_flag: assert property (acc |=> obj_err == !$past(known)) else $error("bad err flag");
    a_enable_last: assert property ($rose(servo_enabled) |->
        $past(cmd && obj_wdata[15:0] == `DMES_CW_ENABLE)) else $error("enable without 15");
    a_disable_word: assert property (cmd && obj_wdata[15:0] == `DMES_CW_SHUTDOWN
        |=> !servo_enabled) else $error("enabled after 6");
    a_display_on: assert property (servo_enabled |->
        display_code[7:4] == `DMES_DISP_PREFIX) else $error("display prefix wrong");
    a_display_off: assert property (!servo_enabled |->
        display_code == `DMES_DISP_IDLE) else $error("display not idle");
    // Store takes one edge and the registered decode a second one
    a_mode_csv: assert property (obj_wr && obj_index == `DMES_OFS_MODE &&
        obj_wdata[7:0] == `DMES_MODE_CSV |=> ##1 active_op == DMES_OP_CSV)
        else $error("mode 9 lost");
    // A start needs the word, the enabled state and position mode together
    a_start_cause: assert property (move_start |-> $past(cmd && servo_enabled &&
        active_op == DMES_OP_PP && obj_wdata[15:0] inside {`DMES_CW_START_A,
        `DMES_CW_START_B})) else $error("stray move start");
    // Three cycles cover the two register stages behind the motion flag
    a_pv_still: assert property ((active_op == DMES_OP_PV &&
        accel_cfg == 16'h0000) [*3] |-> !motion_active) else $error("motion with zero accel");
    a_off_still: assert property ((!servo_enabled) [*2] |-> !motion_active)
        else $error("motion while disabled");
endmodule
bind dmes_sequencer dmes_seq_asserts u_chk (
    .clk(clk), .rst_n(rst_n), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_err(obj_err), .accel_cfg(accel_cfg),
    .servo_enabled(servo_enabled), .display_code(display_code), .active_op(active_op),
    .motion_active(motion_active), .move_start(move_start)
);
`default_nettype wire

// ---- bench/dmes_host.sv ----
`include "dmes_map.svh"
`default_nettype none
// Fieldbus master model issuing object accesses
module dmes_host (
    input wire logic clk,
    input wire logic obj_ack,
    input wire logic obj_err,
    input wire logic [31:0] obj_rdata,
    output logic obj_wr,
    output logic obj_rd,
    output logic [15:0] obj_index,
    output logic [31:0] obj_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] hq; // Answer of internal sequences
    logic ha;
    logic he;
    initial begin
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h0000_0000;
    end
    // One-edge strobe; answer sampled one edge later
    task automatic xfer(input logic rd, input logic [15:0] idx, input logic [31:0] d,
            output logic [31:0] q, output logic ack, output logic err);
        @(posedge clk);
        #1;
        obj_wr = !rd;
        obj_rd = rd;
        obj_index = idx;
        obj_wdata = d;
        @(posedge clk);
        #1;
        q = obj_rdata;
        ack = obj_ack;
        err = obj_err;
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_wdata = ~d; // Released data must not look like the last word
    endtask
    // Cycle period and data mapping count as set before this model runs
    // so any mode, cyclic ones too, may be selected at once
    // Enable only by the fixed word order
    task automatic enable();
        xfer(1'b0, `DMES_OFS_CMD, 32'h6, hq, ha, he);
        xfer(1'b0, `DMES_OFS_CMD, 32'h7, hq, ha, he);
        xfer(1'b0, `DMES_OFS_CMD, 32'hF, hq, ha, he);
    endtask
    // Zero the target first, disable after, so the axis stops cleanly
    task automatic stop(input logic [15:0] idx);
        xfer(1'b0, idx, 32'h0, hq, ha, he);
        xfer(1'b0, `DMES_OFS_CMD, 32'h6, hq, ha, he);
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_drive_mode_enable_sequencer.sv ----
`include "dmes_map.svh"
`default_nettype none
module tb_drive_mode_enable_sequencer
    import dmes_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic obj_wr, obj_rd, obj_ack, obj_err, servo_enabled, motion_active, move_start;
    logic [15:0] obj_index, accel_cfg, decel_cfg, torque_ramp_cfg, speed_limit_cfg;
    logic [15:0] gear_num, gear_den;
    logic [31:0] obj_wdata, obj_rdata, pos_cmd, q;
    logic signed [31:0] vel_cmd;
    logic signed [15:0] trq_cmd_permille;
    logic [7:0] display_code;
    dmes_op_t active_op;
    logic a, e;
    int n_fail = 0;
    int n_tests = 0;
    logic [7:0] mode_v [7] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
    dmes_op_t op_v [7] = '{DMES_OP_PP, DMES_OP_PV, DMES_OP_PT, DMES_OP_HOME, DMES_OP_CSP,
        DMES_OP_CSV, DMES_OP_CST};
    always #20 clk = ~clk;
    dmes_sequencer dut (
        .clk(clk), .rst_n(rst_n), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index),
        .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
        .accel_cfg(accel_cfg), .decel_cfg(decel_cfg), .torque_ramp_cfg(torque_ramp_cfg),
        .speed_limit_cfg(speed_limit_cfg), .gear_num(gear_num), .gear_den(gear_den),
        .servo_enabled(servo_enabled), .display_code(display_code), .active_op(active_op),
        .motion_active(motion_active), .move_start(move_start), .pos_cmd(pos_cmd),
        .vel_cmd(vel_cmd), .trq_cmd_permille(trq_cmd_permille)
    );
    dmes_host host (
        .clk(clk), .obj_ack(obj_ack), .obj_err(obj_err), .obj_rdata(obj_rdata),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index), .obj_wdata(obj_wdata)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        host.xfer(1'b0, idx, d, q, a, e);
        chk({e, a}, 32'h1); // Mapped write answered without error
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Mode set first, then enable, then disable
    task automatic run_mode(input logic [7:0] m, input dmes_op_t op);
        wr(`DMES_OFS_MODE, {24'h0, m});
        settle(1); // Decode is registered one edge after the store
        chk(active_op, op);
        host.xfer(1'b1, `DMES_OFS_MODE, 32'h0, q, a, e);
        chk(q[7:0], m);
        host.enable();
        chk(servo_enabled, 1'b1);
        chk(display_code, {`DMES_DISP_PREFIX, m[3:0]});
        wr(`DMES_OFS_CMD, 32'h6);
        chk({servo_enabled, display_code}, 32'h0);
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial begin
        accel_cfg = 16'h0000;
        decel_cfg = 16'h0040;
        torque_ramp_cfg = 16'h0000;
        speed_limit_cfg = 16'h0000;
        gear_num = 16'h0003;
        gear_den = 16'h0002;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(active_op, DMES_OP_NONE); // Idle after reset
        chk({servo_enabled, display_code}, 32'h0);
        host.xfer(1'b1, 16'h6041, 32'h0, q, a, e);
        chk({e, a}, 32'h3); // Unmapped index flagged
        wr(`DMES_OFS_CMD, 32'hF);
        chk(servo_enabled, 1'b0);
        for (int i = 0; i < 7; i++) begin
            run_mode(mode_v[i], op_v[i]);
        end
        // Torque setpoint passes in permille units
        wr(`DMES_OFS_MODE, 32'hA);
        host.enable();
        wr(`DMES_OFS_TRQ, 32'h1F4);
        settle(1);
        chk(trq_cmd_permille, 32'h1F4);
        host.stop(`DMES_OFS_TRQ);
        // Profile torque stays still until ramp and limit both set
        wr(`DMES_OFS_MODE, 32'h4);
        host.enable();
        wr(`DMES_OFS_TRQ, 32'h64);
        settle(3);
        chk(motion_active, 1'b0);
        torque_ramp_cfg = 16'h0010;
        settle(3);
        chk(motion_active, 1'b0);
        speed_limit_cfg = 16'h0100;
        settle(3);
        chk(motion_active, 1'b1);
        host.stop(`DMES_OFS_TRQ);
        // Profile velocity, target only once enabled
        wr(`DMES_OFS_MODE, 32'h3);
        host.enable();
        wr(`DMES_OFS_VEL, 32'h64);
        settle(3);
        chk(motion_active, 1'b0);
        accel_cfg = 16'h0010;
        settle(3);
        chk(motion_active, 1'b1);
        // A zero deceleration alone must also hold the axis
        decel_cfg = 16'h0000;
        settle(3);
        chk(motion_active, 1'b0);
        decel_cfg = 16'h0040;
        settle(3);
        chk(motion_active, 1'b1);
        host.stop(`DMES_OFS_VEL);
        settle(2);
        chk(motion_active, 1'b0);
        // Gear 3/2 on a negative speed; gear stage and command stage both register
        wr(`DMES_OFS_MODE, 32'h9);
        host.enable();
        wr(`DMES_OFS_VEL, 32'hFFFF_FC18);
        settle(2);
        chk(vel_cmd, 32'hFFFF_FA24);
        host.stop(`DMES_OFS_VEL);
        // Position first, then both start words
        wr(`DMES_OFS_MODE, 32'h1);
        host.enable();
        wr(`DMES_OFS_POS, 32'h0001_2345);
        settle(1);
        chk(pos_cmd, 32'h0001_2345);
        wr(`DMES_OFS_CMD, 32'h1F);
        chk(move_start, 1'b1);
        settle(1);
        chk(move_start, 1'b0);
        wr(`DMES_OFS_CMD, 32'h5F);
        chk(move_start, 1'b1);
        wr(`DMES_OFS_CMD, 32'h6);
        chk(servo_enabled, 1'b0);
        wr(`DMES_OFS_CMD, 32'h1F);
        chk(move_start, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
